// *** src/pmi_pkg.sv ***
package pmi_pkg;

  // --------------------------------------------------------------------------
  // register offsets (8-bit register address space)
  // --------------------------------------------------------------------------
  localparam logic [7:0] PMI_SOFT_RESET_CONTROL = 8'h18;
  localparam logic [7:0] PMI_TOP_EVENT_FLAGS_1 = 8'h19;
  localparam logic [7:0] PMI_TOP_EVENT_FLAGS_2 = 8'h1A;
  localparam logic [7:0] PMI_STEPDOWN_EVENT_FLAGS = 8'h1B;
  localparam logic [7:0] PMI_LINREG_EVENT_FLAGS = 8'h1C;
  localparam logic [7:0] PMI_TOP_LIVE_STATUS = 8'h1D;
  localparam logic [7:0] PMI_IRQ_MASK = 8'h20;

  // --------------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------------
  localparam int PMI_SOFT_RESET_BIT = 0;
  localparam int PMI_PG_DROP_BIT = 7;
  localparam int PMI_LINREG_SUM_BIT = 6;
  localparam int PMI_STEPDOWN_SUM_BIT = 5;
  localparam int PMI_CLK_CHANGE_BIT = 4;
  localparam int PMI_TSD_BIT = 3;
  localparam int PMI_TWARN_BIT = 2;
  localparam int PMI_OVP_BIT = 1;
  localparam int PMI_MEAS_BIT = 0;
  localparam int PMI_RESET_OCC_BIT = 0;
  // per-regulator group: unit 1 at bits 6..4, unit 0 at bits 2..0
  localparam int PMI_UNIT_STRIDE = 4;
  localparam int PMI_PG_OFS = 2;
  localparam int PMI_SC_OFS = 1;
  localparam int PMI_ILIM_OFS = 0;
  localparam logic [7:0] PMI_UNIT_FLAG_MASK = 8'h77;
  localparam logic [7:0] PMI_TOP1_W1C_MASK = 8'h9F;

  // --------------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0] PMI_REG_RESET = 8'h00;
  localparam logic [7:0] PMI_MASK_RESET = 8'h00;

  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int PMI_CLK_HZ = 40_000_000;
  localparam int PMI_SHORT_TIME_US = 1000;
  localparam int PMI_SHORT_CYCLES = (PMI_CLK_HZ / 1_000_000) * PMI_SHORT_TIME_US;
  localparam int PMI_RESET_HOLD_CYCLES = 4;

  typedef enum logic [1:0] {
    PMI_ST_RUN,
    PMI_ST_RESET,
    PMI_ST_RELOAD
  } pmi_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmi_req_s;

  // raw analog status per regulator unit
  typedef struct packed {
    logic pg_event;
    logic below_sc;
    logic ilim;
  } pmi_unit_s;

endpackage

// *** src/pmi_short_timer.sv ***
module pmi_short_timer
  import pmi_pkg::*;
#(
  parameter int CYCLES = PMI_SHORT_CYCLES
)
(
  input wire logic mclk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic below, // output below short threshold
  output logic expired // one-cycle pulse when held past limit
);

  typedef struct packed {
    logic [31:0] cnt;
    logic fired;
  } pmi_tmr_s;

  pmi_tmr_s st_q;
  pmi_tmr_s st_d;

  always_comb
  begin
    st_d = st_q;
    expired = 1'b0;
    if (!below)
    begin
      st_d.cnt = '0;
      st_d.fired = 1'b0;
    end
    else if (!st_q.fired)
    begin
      // strictly longer than the limit
      if (st_q.cnt >= 32'(CYCLES))
      begin
        expired = 1'b1;
        st_d.fired = 1'b1;
      end
      else
      begin
        st_d.cnt = st_q.cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      st_q <= '0;
    else if (ce)
      st_q <= st_d;
  end

endmodule // pmi_short_timer

// *** src/pmi_irq_ctrl.sv ***
module pmi_irq_ctrl
  import pmi_pkg::*;
#(
  parameter int SHORT_CYCLES = PMI_SHORT_CYCLES
)
(
  input wire logic mclk, // system clock, 40 MHz
  input wire logic rstn, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire pmi_req_s req, // register access from serial interface
  output logic [7:0] rdata, // read data, registered
  input wire logic power_good_out, // power-good pin state, 1 = active
  input wire logic ext_clk_present, // external sync clock detected
  input wire logic tsd_raw, // die over shutdown level
  input wire logic twarn_raw, // die over warning level
  input wire logic ovp_raw, // input over overvoltage level
  input wire logic meas_done, // new current result stored, pulse
  input wire logic analog_supply_uv, // analog supply undervoltage
  input wire pmi_unit_s [1:0] stepdown, // step-down raw status
  input wire pmi_unit_s [1:0] linreg, // linear regulator raw status
  input wire logic [3:0] reg_en_req, // regulator enable requests
  output logic [3:0] reg_en, // gated regulator enables
  output logic general_output_force_low, // force both general outputs low
  output logic soft_reset_pulse, // reset of registers and interface
  output logic fuse_reload, // reload configuration from fuses
  output logic irq_n // interrupt request, active low
);

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  localparam int NSYNC = 18;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;

  assign raw_in = {power_good_out, ext_clk_present, tsd_raw, twarn_raw, ovp_raw,
                   analog_supply_uv, stepdown[1], stepdown[0], linreg[1], linreg[0]};

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else if (ce)
    begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  logic pg_s;
  logic clk_s;
  logic tsd_s;
  logic twarn_s;
  logic ovp_s;
  logic uv_s;
  pmi_unit_s [3:0] unit_s;
  assign {pg_s, clk_s, tsd_s, twarn_s, ovp_s, uv_s, unit_s} = sync2_q;

  // --------------------------------------------------------------------------
  // short-circuit timers, index 3..2 step-down, 1..0 linear regulator
  // --------------------------------------------------------------------------
  logic [3:0] sc_hit;

  for (genvar i = 0; i < 4; i++)
  begin : g_sc
    pmi_short_timer #(.CYCLES(SHORT_CYCLES)) u_tmr (
      .mclk(mclk),
      .rstn(rstn),
      .ce(ce),
      .below(unit_s[i].below_sc),
      .expired(sc_hit[i])
    );
  end

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    pmi_state_e fsm;
    logic [2:0] hold;
    logic [7:0] top1;
    logic [7:0] top2;
    logic [7:0] sdn;
    logic [7:0] lin;
    logic [7:0] mask;
    logic soft_cmd;
    logic pg_prev;
    logic clk_prev;
    logic tsd_prev;
    logic twarn_prev;
    logic ovp_prev;
    logic uv_prev;
    pmi_unit_s [3:0] unit_prev;
    logic [7:0] rdata;
  } pmi_ctl_s;

  pmi_ctl_s st_q;
  pmi_ctl_s st_d;

  logic wr_top1;
  logic wr_top2;
  logic wr_sdn;
  logic wr_lin;
  logic [7:0] top1_rd;
  logic [7:0] live_rd;

  always_comb
  begin
    wr_top1 = 1'b0;
    wr_top2 = 1'b0;
    wr_sdn = 1'b0;
    wr_lin = 1'b0;
    if (req.wr && req.addr == PMI_TOP_EVENT_FLAGS_1)
      wr_top1 = 1'b1;
    else if (req.wr && req.addr == PMI_TOP_EVENT_FLAGS_2)
      wr_top2 = 1'b1;
    else if (req.wr && req.addr == PMI_STEPDOWN_EVENT_FLAGS)
      wr_sdn = 1'b1;
    else if (req.wr && req.addr == PMI_LINREG_EVENT_FLAGS)
      wr_lin = 1'b1;
  end

  // summaries are pure functions of the group registers
  always_comb
  begin
    top1_rd = st_q.top1;
    top1_rd[PMI_LINREG_SUM_BIT] = |st_q.lin;
    top1_rd[PMI_STEPDOWN_SUM_BIT] = |st_q.sdn;
    live_rd = '0;
    live_rd[PMI_TSD_BIT] = tsd_s;
    live_rd[PMI_TWARN_BIT] = twarn_s;
    live_rd[PMI_OVP_BIT] = ovp_s;
  end

  always_comb
  begin
    st_d = st_q;
    st_d.pg_prev = pg_s;
    st_d.clk_prev = clk_s;
    st_d.tsd_prev = tsd_s;
    st_d.twarn_prev = twarn_s;
    st_d.ovp_prev = ovp_s;
    st_d.uv_prev = uv_s;
    st_d.unit_prev = unit_s;

    // clears first, so a same-cycle event below wins
    if (wr_top1)
      st_d.top1 = st_q.top1 & ~(req.wdata & PMI_TOP1_W1C_MASK);
    if (wr_top2)
      st_d.top2[PMI_RESET_OCC_BIT] = st_q.top2[PMI_RESET_OCC_BIT] & ~req.wdata[PMI_RESET_OCC_BIT];
    if (wr_sdn)
      st_d.sdn = st_q.sdn & ~(req.wdata & PMI_UNIT_FLAG_MASK);
    if (wr_lin)
      st_d.lin = st_q.lin & ~(req.wdata & PMI_UNIT_FLAG_MASK);
    if (req.wr && req.addr == PMI_IRQ_MASK)
      st_d.mask = req.wdata;
    if (req.wr && req.addr == PMI_SOFT_RESET_CONTROL && req.wdata[PMI_SOFT_RESET_BIT])
      st_d.soft_cmd = 1'b1;

    if (st_q.pg_prev && !pg_s)
      st_d.top1[PMI_PG_DROP_BIT] = 1'b1;
    if (st_q.clk_prev != clk_s)
      st_d.top1[PMI_CLK_CHANGE_BIT] = 1'b1;
    if (tsd_s && !st_q.tsd_prev)
      st_d.top1[PMI_TSD_BIT] = 1'b1;
    if (twarn_s && !st_q.twarn_prev)
      st_d.top1[PMI_TWARN_BIT] = 1'b1;
    if (ovp_s && !st_q.ovp_prev)
      st_d.top1[PMI_OVP_BIT] = 1'b1;
    if (meas_done)
      st_d.top1[PMI_MEAS_BIT] = 1'b1;

    for (int u = 0; u < 2; u++)
    begin
      if (unit_s[u+2].pg_event && !st_q.unit_prev[u+2].pg_event)
        st_d.sdn[u*PMI_UNIT_STRIDE+PMI_PG_OFS] = 1'b1;
      if (sc_hit[u+2])
        st_d.sdn[u*PMI_UNIT_STRIDE+PMI_SC_OFS] = 1'b1;
      if (unit_s[u+2].ilim)
        st_d.sdn[u*PMI_UNIT_STRIDE+PMI_ILIM_OFS] = 1'b1;
      if (unit_s[u].pg_event && !st_q.unit_prev[u].pg_event)
        st_d.lin[u*PMI_UNIT_STRIDE+PMI_PG_OFS] = 1'b1;
      if (sc_hit[u])
        st_d.lin[u*PMI_UNIT_STRIDE+PMI_SC_OFS] = 1'b1;
      if (unit_s[u].ilim)
        st_d.lin[u*PMI_UNIT_STRIDE+PMI_ILIM_OFS] = 1'b1;
    end

    case (st_q.fsm)
      PMI_ST_RUN:
      begin
        if (st_q.soft_cmd || (uv_s && !st_q.uv_prev))
        begin
          st_d.fsm = PMI_ST_RESET;
          st_d.hold = '0;
        end
      end
      PMI_ST_RESET:
      begin
        // defaults restored; flag of the reset itself survives
        st_d.top1 = PMI_REG_RESET;
        st_d.sdn = PMI_REG_RESET;
        st_d.lin = PMI_REG_RESET;
        st_d.mask = PMI_MASK_RESET;
        st_d.soft_cmd = 1'b0;
        st_d.fsm = PMI_ST_RELOAD;
      end
      PMI_ST_RELOAD:
      begin
        st_d.soft_cmd = 1'b0;
        st_d.hold = st_q.hold + 3'h1;
        if (st_q.hold == 3'(PMI_RESET_HOLD_CYCLES - 1))
        begin
          st_d.top2[PMI_RESET_OCC_BIT] = 1'b1;
          st_d.fsm = PMI_ST_RUN;
        end
      end
      default:
        st_d.fsm = PMI_ST_RUN;
    endcase

    // read data
    st_d.rdata = st_q.rdata;
    if (req.rd)
    begin
      if (req.addr == PMI_SOFT_RESET_CONTROL)
        st_d.rdata = 8'h00;
      else if (req.addr == PMI_TOP_EVENT_FLAGS_1)
        st_d.rdata = top1_rd;
      else if (req.addr == PMI_TOP_EVENT_FLAGS_2)
        st_d.rdata = st_q.top2;
      else if (req.addr == PMI_STEPDOWN_EVENT_FLAGS)
        st_d.rdata = st_q.sdn;
      else if (req.addr == PMI_LINREG_EVENT_FLAGS)
        st_d.rdata = st_q.lin;
      else if (req.addr == PMI_TOP_LIVE_STATUS)
        st_d.rdata = live_rd;
      else if (req.addr == PMI_IRQ_MASK)
        st_d.rdata = st_q.mask;
      else
        st_d.rdata = 8'h00;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= '0;
      st_q.fsm <= PMI_ST_RUN;
      st_q.mask <= PMI_MASK_RESET;
    end
    else if (ce)
      st_q <= st_d;
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  logic fault_off;
  assign fault_off = st_q.top1[PMI_TSD_BIT] || st_q.top1[PMI_OVP_BIT];

  // shutdown or overvoltage flag held means enables stay off until host or a reset clears it
  assign reg_en = (fault_off || st_q.fsm != PMI_ST_RUN) ? 4'h0 : reg_en_req;
  assign general_output_force_low = fault_off;
  assign soft_reset_pulse = (st_q.fsm == PMI_ST_RESET);
  assign fuse_reload = (st_q.fsm == PMI_ST_RELOAD);
  assign rdata = st_q.rdata;
  assign irq_n = ~(|(top1_rd & ~st_q.mask) || st_q.top2[PMI_RESET_OCC_BIT]);

endmodule // pmi_irq_ctrl

// *** sim/pmi_host_model.sv ***
module pmi_host_model
  import pmi_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic [7:0] rdata, // read data from block
  output pmi_req_s req // register request to block
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // host bus cycles
  // ----
  initial req = '0;
  // a one acknowledges a flag, a zero leaves it alone
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // released bus shows inverted values so stale data cannot pass
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    // rdata holds until the next read, so take it on the following edge
    @(posedge mclk);
    d = rdata;
  endtask
endmodule // pmi_host_model

// *** sim/pmi_irq_ctrl_asserts.sv ***
module pmi_irq_ctrl_asserts
  import pmi_pkg::*;
#(
  parameter int SHORT_CYCLES = PMI_SHORT_CYCLES
)
(
  input wire logic mclk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic ce, // clock enable
  input wire pmi_req_s req, // register request
  input wire logic tsd_raw, // shutdown level crossed
  input wire logic ovp_raw, // overvoltage level crossed
  input wire logic [3:0] reg_en_req, // enable requests
  input wire logic [3:0] reg_en, // gated enables
  input wire logic general_output_force_low, // outputs forced low
  input wire logic soft_reset_pulse, // reset pulse
  input wire logic fuse_reload, // fuse reload
  input wire logic irq_n // interrupt, active low
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_cmd;
    ce && req.wr && req.addr == PMI_SOFT_RESET_CONTROL && req.wdata[PMI_SOFT_RESET_BIT];
  endsequence
  sequence s_reload;
    fuse_reload[*4] ##1 !fuse_reload;
  endsequence
  a_soft_reset_start: assert property (s_cmd |-> ##2 soft_reset_pulse) else $error("no reset pulse");
  a_fuse_reload_len: assert property (soft_reset_pulse |=> s_reload) else $error("bad reload length");
  a_cmd_self_clear: assert property (soft_reset_pulse |=> !soft_reset_pulse[*4]) else $error("pulse repeats");
  a_tsd_force_low: assert property ($rose(tsd_raw) |-> ##[1:4] general_output_force_low)
    else $error("no force low on shutdown");
  a_ovp_force_low: assert property ($rose(ovp_raw) |-> ##[1:4] general_output_force_low)
    else $error("no force low on overvoltage");
  a_fault_gates_en: assert property ($rose(general_output_force_low) |-> (reg_en == 4'h0)[*3])
    else $error("enable while fault");
  a_gate_release: assert property ($fell(general_output_force_low) && !soft_reset_pulse && !fuse_reload
    |-> ##1 reg_en == reg_en_req) else $error("enable not restored");
  a_reset_irq: assert property (soft_reset_pulse |-> ##[1:8] !irq_n) else $error("no reset interrupt");
endmodule // pmi_irq_ctrl_asserts

bind pmi_irq_ctrl pmi_irq_ctrl_asserts #(.SHORT_CYCLES(SHORT_CYCLES)) u_pmi_irq_ctrl_asserts (.mclk(mclk),
  .rstn(rstn), .ce(ce), .req(req), .tsd_raw(tsd_raw), .ovp_raw(ovp_raw), .reg_en_req(reg_en_req),
  .reg_en(reg_en), .general_output_force_low(general_output_force_low), .soft_reset_pulse(soft_reset_pulse),
  .fuse_reload(fuse_reload), .irq_n(irq_n));

// *** sim/testbench.sv ***
module testbench;
  import pmi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 20;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic power_good_out = 1'b1, ext_clk_present = 1'b0, tsd_raw = 1'b0, twarn_raw = 1'b0, ovp_raw = 1'b0;
  logic meas_done = 1'b0, analog_supply_uv = 1'b0;
  pmi_unit_s [1:0] stepdown = '0, linreg = '0;
  logic [3:0] reg_en_req = 4'hF;
  pmi_req_s req;
  logic [7:0] rdata;
  logic [3:0] reg_en;
  logic general_output_force_low, soft_reset_pulse, fuse_reload, irq_n;
  int error_cnt = 0, samples_checked = 0, cycles = 0;
  always #12.5 mclk = ~mclk;
  pmi_irq_ctrl #(.SHORT_CYCLES(SC)) u_pmi_irq_ctrl (.mclk(mclk), .rstn(rstn), .ce(ce), .req(req),
    .rdata(rdata), .power_good_out(power_good_out), .ext_clk_present(ext_clk_present), .tsd_raw(tsd_raw),
    .twarn_raw(twarn_raw), .ovp_raw(ovp_raw), .meas_done(meas_done), .analog_supply_uv(analog_supply_uv),
    .stepdown(stepdown), .linreg(linreg), .reg_en_req(reg_en_req), .reg_en(reg_en),
    .general_output_force_low(general_output_force_low), .soft_reset_pulse(soft_reset_pulse),
    .fuse_reload(fuse_reload), .irq_n(irq_n));
  pmi_host_model u_pmi_host_model (.mclk(mclk), .rdata(rdata), .req(req));
  // ----
  // helpers
  // ----
  task automatic complete_run;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_pmi_host_model.rd(a, d);
    chk(d, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // pins reach the flags through two sync stages, so settle before reading
  task automatic set_top(input int i, input logic v);
    @(posedge mclk);
    case (i)
      0: tsd_raw <= v;
      1: twarn_raw <= v;
      default: ovp_raw <= v;
    endcase
    idle(5);
  endtask
  task automatic set_unit(input int u, input pmi_unit_s v, input int n);
    @(posedge mclk);
    if (u < 2)
      stepdown[u] <= v;
    else
      linreg[u - 2] <= v;
    idle(n);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_defaults;
    logic [7:0] a [6] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h30};
    foreach (a[i]) rdchk(a[i], PMI_REG_RESET);
    chk({7'h0, irq_n}, 8'h01);
  endtask
  task automatic t_soft_reset;
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0)
        u_pmi_host_model.wr(PMI_SOFT_RESET_CONTROL, 8'h01);
      else
        analog_supply_uv <= 1'b1;
      idle(10);
      analog_supply_uv <= 1'b0;
      rdchk(PMI_SOFT_RESET_CONTROL, 8'h00);
      rdchk(PMI_TOP_EVENT_FLAGS_2, 8'h01);
      chk({7'h0, irq_n}, 8'h00);
      u_pmi_host_model.wr(PMI_TOP_EVENT_FLAGS_2, 8'h00);
      rdchk(PMI_TOP_EVENT_FLAGS_2, 8'h01);
      u_pmi_host_model.wr(PMI_TOP_EVENT_FLAGS_2, 8'h01);
      rdchk(PMI_TOP_EVENT_FLAGS_2, 8'h00);
      chk({7'h0, irq_n}, 8'h01);
    end
  endtask
  task automatic t_faults;
    logic [7:0] e;
    for (int i = 0; i < 3; i++)
    begin
      e = 8'h08 >> i;
      set_top(i, 1'b1);
      rdchk(PMI_TOP_EVENT_FLAGS_1, e);
      rdchk(PMI_TOP_LIVE_STATUS, e);
      chk({4'h0, reg_en}, (i == 1) ? 8'h0F : 8'h00);
      chk({7'h0, general_output_force_low}, (i == 1) ? 8'h00 : 8'h01);
      set_top(i, 1'b0);
      rdchk(PMI_TOP_LIVE_STATUS, 8'h00);
      rdchk(PMI_TOP_EVENT_FLAGS_1, e);
      u_pmi_host_model.wr(PMI_TOP_EVENT_FLAGS_1, e);
      rdchk(PMI_TOP_EVENT_FLAGS_1, 8'h00);
      chk({4'h0, reg_en}, 8'h0F);
    end
  endtask
  task automatic t_events;
    @(posedge mclk);
    power_good_out <= 1'b0;
    idle(5);
    rdchk(PMI_TOP_EVENT_FLAGS_1, 8'h80);
    u_pmi_host_model.wr(PMI_TOP_EVENT_FLAGS_1, 8'h80);
    power_good_out <= 1'b1;
    idle(5);
    rdchk(PMI_TOP_EVENT_FLAGS_1, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      ext_clk_present <= !k[0];
      idle(5);
      rdchk(PMI_TOP_EVENT_FLAGS_1, 8'h10);
      // a masked pending flag must not raise the request
      u_pmi_host_model.wr(PMI_IRQ_MASK, 8'hFF);
      idle(1);
      chk({7'h0, irq_n}, 8'h01);
      u_pmi_host_model.wr(PMI_IRQ_MASK, 8'h00);
      idle(1);
      chk({7'h0, irq_n}, 8'h00);
      u_pmi_host_model.wr(PMI_TOP_EVENT_FLAGS_1, 8'h10);
      idle(1);
      chk({7'h0, irq_n}, 8'h01);
    end
    meas_done <= 1'b1;
    @(posedge mclk);
    meas_done <= 1'b0;
    idle(2);
    rdchk(PMI_TOP_EVENT_FLAGS_1, 8'h01);
    u_pmi_host_model.wr(PMI_TOP_EVENT_FLAGS_1, 8'h01);
  endtask
  task automatic t_units;
    logic [7:0] a, s;
    int sh;
    for (int u = 0; u < 4; u++)
    begin
      a = (u < 2) ? PMI_STEPDOWN_EVENT_FLAGS : PMI_LINREG_EVENT_FLAGS;
      s = (u < 2) ? 8'h20 : 8'h40;
      sh = (u % 2) * PMI_UNIT_STRIDE;
      set_unit(u, 3'b001, 5);
      set_unit(u, 3'b000, 4);
      rdchk(a, 8'h01 << sh);
      rdchk(PMI_TOP_EVENT_FLAGS_1, s);
      u_pmi_host_model.wr(a, 8'h01 << sh);
      rdchk(PMI_TOP_EVENT_FLAGS_1, 8'h00);
      set_unit(u, 3'b100, 5);
      set_unit(u, 3'b000, 4);
      rdchk(a, 8'h04 << sh);
      u_pmi_host_model.wr(a, 8'h04 << sh);
      set_unit(u, 3'b010, SC - 5);
      set_unit(u, 3'b000, 4);
      rdchk(a, 8'h00);
      set_unit(u, 3'b010, SC + 6);
      set_unit(u, 3'b000, 4);
      rdchk(a, 8'h02 << sh);
      u_pmi_host_model.wr(a, 8'h02 << sh);
      rdchk(a, 8'h00);
    end
  endtask
  initial
  begin
    idle(2);
    rstn <= 1'b1;
    @(posedge mclk);
    t_defaults();
    t_soft_reset();
    t_faults();
    t_events();
    t_units();
    complete_run();
  end
endmodule // testbench
